// File: das_pkg.sv
/*
 das_pkg: constants, carrier structs, state enums and decode helpers
 for the dual converter output and configuration block.
 assumes: compiled before every other file of the block.
*/
// How it works
// - each rising encode edge outside power-down starts a conversion of both channels together.
// - serial port shifts configuration only while chip select is low.
// - serial data input is sampled on each rising serial clock edge.
// - readback bits are driven after falling serial clock edges.
// - serial data output only pulls low; readback is optional.
// - static mode pin picks serial or parallel programming.
// - parallel mode: chip select level picks two-lane or one-lane output.
// - parallel mode: serial clock level picks output driver current.
// - parallel mode: serial data input level commands power-down.
// - parallel mode: serial data output pin enables output termination.
// - one-lane mode uses only each channel's first lane.
// - sixteen-bit mode pads each sample with zero bits.
// - two-lane fourteen-bit mode gives a frame period of two samples.
// - sixteen, fourteen and twelve bit serialization in both lane modes.
// - parallel mode keeps the duty cycle stabilizer enabled.
package das_pkg;
   // ==========================================
   // sizes and timing counts
   localparam int RES_W = 12;
   localparam int PIPE_LAT = 6;
   localparam int FIFO_DEPTH = 4;
   localparam logic [4:0] CMD_LAST = 5'h07;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   // ==========================================
   // configuration registers and fields
   localparam logic [6:0] REG_POWER_ADDR = 7'h01;
   localparam logic [6:0] REG_OUTPUT_ADDR = 7'h02;
   localparam logic [7:0] REG_POWER_RST = 8'h02;
   localparam logic [7:0] REG_OUTPUT_RST = 8'h00;
   localparam int PWR_DOWN_BIT = 0;
   localparam int PWR_DCS_BIT = 1;
   localparam int OUT_ONE_LANE_BIT = 0;
   localparam int OUT_LEN_LSB = 1;
   localparam int OUT_CURRENT_BIT = 3;
   localparam int OUT_TERM_BIT = 4;
   localparam logic [1:0] LEN_16 = 2'h0;
   localparam logic [1:0] LEN_14 = 2'h1;
   localparam logic [1:0] LEN_12 = 2'h2;
   // ==========================================
   // carriers and states
   typedef struct packed {
      logic power_down;
      logic dcs_enable;
      logic drive_low;
      logic term_enable;
      logic one_lane;
      logic [1:0] ser_len;
   } das_cfg_t;
   typedef struct packed {
      logic [RES_W-1:0] chan1;
      logic [RES_W-1:0] chan2;
      logic one_lane;
      logic [1:0] ser_len;
   } das_word_t;
   localparam int WORD_W = $bits(das_word_t);
   typedef enum logic [1:0] {SP_IDLE = 2'b00, SP_CMD = 2'b01, SP_DATA = 2'b11} das_spi_st_t;
   typedef enum logic {LK_IDLE = 1'b0, LK_SEND = 1'b1} das_lk_st_t;
   // ==========================================
   // bits each lane carries per sample
   function automatic logic [4:0] das_bits_per_lane(input logic one_lane, input logic [1:0] ser_len);
      logic [4:0] n;
      n = 5'h10;
      if (ser_len == LEN_14) n = 5'h0E;
      if (ser_len == LEN_12) n = 5'h0C;
      return one_lane ? n : (n >> 1);
   endfunction
endpackage

// File: das_fifo.sv
/*
 das_fifo: small synchronous FIFO with valid/ready on both sides.
 assumes: DEPTH is a power of two; one clock for both sides.
*/
module das_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input logic clk,
   input logic nrst,
   // fill side
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   logic full;
   assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = (wp != rp);
   assign out_data = mem[rp[AW-1:0]];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp <= '0;
      end else if (in_valid && !full) begin
         wp <= wp + (AW+1)'(1);
      end
   end
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rp <= '0;
      end else if (out_ready && (wp != rp)) begin
         rp <= rp + (AW+1)'(1);
      end
   end
endmodule // das_fifo

// File: das_spi_cfg.sv
/*
 das_spi_cfg: serial configuration port and parallel pin decode.
 assumes: pins are asynchronous; serial clock slower than clk / 5.
*/
module das_spi_cfg (
   // clock and reset
   input logic clk,
   input logic nrst,
   // control pins
   input logic programming_mode_select,
   input logic cs_n,
   input logic sck,
   input logic sdi,
   input logic sdo_i,
   output logic sdo_o,
   output logic sdo_oe,
   // resulting configuration
   output das_pkg::das_cfg_t cfg
);
   import das_pkg::*;
   logic [4:0] s1;
   logic [4:0] s2;
   logic sck_d;
   das_spi_st_t state;
   logic [4:0] cnt;
   logic [15:0] shreg;
   logic [7:0] cmd;
   logic [7:0] reg_power;
   logic [7:0] reg_output;
   logic [7:0] rdata;
   logic serial, cs_n_s, sck_s, sdi_s, sdo_s, active, rise, fall, rd_bit;
   assign serial = !s2[4];
   assign cs_n_s = s2[3];
   assign sck_s = s2[2];
   assign sdi_s = s2[1];
   assign sdo_s = s2[0];
   assign active = serial && !cs_n_s;
   assign rise = sck_s && !sck_d;
   assign fall = !sck_s && sck_d;
   assign sdo_o = 1'b0;
   assign rdata = (cmd[6:0] == REG_POWER_ADDR) ? reg_power :
                  (cmd[6:0] == REG_OUTPUT_ADDR) ? reg_output : 8'h00;
   assign rd_bit = rdata[3'(DATA_LAST - cnt)];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= 5'h00;
         s2 <= 5'h00;
         sck_d <= 1'b0;
      end else begin
         s1 <= {programming_mode_select, cs_n, sck, sdi, sdo_i};
         s2 <= s1;
         sck_d <= s2[2];
      end
   end
   // ==========================================
   // shifting
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= SP_IDLE;
         cnt <= 5'h00;
         shreg <= 16'h0000;
         cmd <= 8'h00;
      end else if (!active) begin
         state <= SP_IDLE;
         cnt <= 5'h00;
      end else if (rise) begin
         shreg <= {shreg[14:0], sdi_s};
         cnt <= cnt + 5'h01;
         state <= (cnt >= CMD_LAST) ? SP_DATA : SP_CMD;
         if (cnt == CMD_LAST) cmd <= {shreg[6:0], sdi_s};
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_power <= REG_POWER_RST;
         reg_output <= REG_OUTPUT_RST;
      end else if (active && rise && cnt == DATA_LAST && !cmd[7]) begin
         if (cmd[6:0] == REG_POWER_ADDR) reg_power <= {shreg[6:0], sdi_s};
         if (cmd[6:0] == REG_OUTPUT_ADDR) reg_output <= {shreg[6:0], sdi_s};
      end
   end
   // readback only pulls low, so a one is the pin left released
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sdo_oe <= 1'b0;
      end else if (!active || (fall && cnt > DATA_LAST)) begin
         sdo_oe <= 1'b0;
      end else if (fall && state == SP_DATA && cmd[7]) begin
         sdo_oe <= !rd_bit;
      end
   end
   // ==========================================
   // configuration select
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= '0;
      end else if (serial) begin
         cfg.power_down <= reg_power[PWR_DOWN_BIT];
         cfg.dcs_enable <= reg_power[PWR_DCS_BIT];
         cfg.one_lane <= reg_output[OUT_ONE_LANE_BIT];
         cfg.ser_len <= reg_output[OUT_LEN_LSB +: 2];
         cfg.drive_low <= reg_output[OUT_CURRENT_BIT];
         cfg.term_enable <= reg_output[OUT_TERM_BIT];
      end else begin
         cfg.one_lane <= cs_n_s;
         cfg.drive_low <= sck_s;
         cfg.power_down <= sdi_s;
         cfg.term_enable <= sdo_s;
         cfg.dcs_enable <= 1'b1;
         cfg.ser_len <= LEN_16;
      end
   end
   // ==========================================
   // checks
   a_cs_gates_shift: assert property (@(posedge clk) disable iff (!nrst)
      !active |=> cnt == 5'h00 && state == SP_IDLE) else $error("shift state kept without chip select");
   a_rise_samples: assert property (@(posedge clk) disable iff (!nrst)
      active && rise |=> shreg[0] == $past(sdi_s)) else $error("data input not sampled on rising edge");
   a_fall_drives: assert property (@(posedge clk) disable iff (!nrst)
      active && fall && state == SP_DATA && cmd[7] && cnt <= DATA_LAST |=> sdo_oe == !$past(rd_bit))
      else $error("readback bit wrong after falling edge");
   a_pull_low_only: assert property (@(posedge clk) disable iff (!nrst)
      sdo_oe |-> !sdo_o && $past(active)) else $error("data output driven outside a read");
   a_par_pins: assert property (@(posedge clk) disable iff (!nrst)
      !serial |=> cfg.one_lane == $past(cs_n_s) && cfg.drive_low == $past(sck_s)
      && cfg.power_down == $past(sdi_s) && cfg.term_enable == $past(sdo_s)) else $error("parallel pin decode wrong");
   a_par_dcs: assert property (@(posedge clk) disable iff (!nrst)
      !serial [*2] |-> cfg.dcs_enable) else $error("stabilizer off in parallel mode");
endmodule // das_spi_cfg

// File: das_top.sv
/*
 das_top: conversion timing, result pipeline, FIFO, crossing to the
 serial bit clock and lane serializer of the dual converter.
 assumes: bit_clk is the free running serial clock; codes are valid
 in the clk domain; encode rate below clk / 3.
*/
module das_top (
   // core clock and reset
   input logic clk,
   input logic nrst,
   // serial bit clock
   input logic bit_clk,
   // conversion
   input logic enc_p,
   input logic [das_pkg::RES_W-1:0] chan1_code,
   input logic [das_pkg::RES_W-1:0] chan2_code,
   // configuration pins
   input logic programming_mode_select,
   input logic cs_n,
   input logic sck,
   input logic sdi,
   input logic sdo_i,
   output logic sdo_o,
   output logic sdo_oe,
   // status
   output das_pkg::das_cfg_t cfg,
   output logic sample_overrun,
   // serial outputs
   output logic chan1_lane_first,
   output logic chan1_lane_second,
   output logic chan2_lane_first,
   output logic chan2_lane_second,
   output logic frame_marker,
   output logic forwarded_bit_clock
);
   import das_pkg::*;
   // ==========================================
   // configuration
   das_spi_cfg u_cfg (
      .clk(clk),
      .nrst(nrst),
      .programming_mode_select(programming_mode_select),
      .cs_n(cs_n),
      .sck(sck),
      .sdi(sdi),
      .sdo_i(sdo_i),
      .sdo_o(sdo_o),
      .sdo_oe(sdo_oe),
      .cfg(cfg)
   );
   // ==========================================
   // encode edge
   logic enc_s1, enc_s2, enc_s3, enc_edge;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         enc_s1 <= 1'b0;
         enc_s2 <= 1'b0;
         enc_s3 <= 1'b0;
      end else begin
         enc_s1 <= enc_p;
         enc_s2 <= enc_s1;
         enc_s3 <= enc_s2;
      end
   end
   assign enc_edge = enc_s2 && !enc_s3;
   // ==========================================
   // result pipeline, one stage per encode cycle
   das_word_t pipe [PIPE_LAT];
   logic pv [PIPE_LAT];
   das_word_t new_word;
   always_comb begin
      new_word.chan1 = chan1_code;
      new_word.chan2 = chan2_code;
      new_word.one_lane = cfg.one_lane;
      new_word.ser_len = cfg.ser_len;
   end
   // both channels share one stage so their delay is identical
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pipe[0] <= '0;
         pv[0] <= 1'b0;
      end else if (enc_edge) begin
         pipe[0] <= new_word;
         pv[0] <= !cfg.power_down;
      end
   end
   generate
      for (genvar i = 1; i < PIPE_LAT; i++) begin : g_pipe
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               pipe[i] <= '0;
               pv[i] <= 1'b0;
            end else if (enc_edge) begin
               pipe[i] <= pipe[i-1];
               pv[i] <= pv[i-1];
            end
         end
      end
   endgenerate
   // ==========================================
   // buffer
   logic f_in_ready, f_push, f_out_valid, f_out_ready;
   logic [WORD_W-1:0] f_out;
   assign f_push = enc_edge && pv[PIPE_LAT-1];
   das_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data(pipe[PIPE_LAT-1]),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out)
   );
   // a full buffer drops the new sample rather than stall the converter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sample_overrun <= 1'b0;
      end else begin
         sample_overrun <= f_push && !f_in_ready;
      end
   end
   // ==========================================
   // word crossing, toggle handshake
   logic req, ack_s1, ack_s2, x_free, lk_ack;
   das_word_t xfer_word;
   assign x_free = (req == ack_s2);
   assign f_out_ready = x_free;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req <= 1'b0;
         xfer_word <= '0;
      end else if (f_out_valid && x_free) begin
         req <= !req;
         xfer_word <= das_word_t'(f_out);
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= lk_ack;
         ack_s2 <= ack_s1;
      end
   end
   // ==========================================
   // link domain reset and request sync
   logic lk_r1, lk_rst_n, rq_s1, rq_s2;
   always_ff @(posedge bit_clk or negedge nrst) begin
      if (!nrst) begin
         lk_r1 <= 1'b0;
         lk_rst_n <= 1'b0;
      end else begin
         lk_r1 <= 1'b1;
         lk_rst_n <= lk_r1;
      end
   end
   always_ff @(posedge bit_clk or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         rq_s1 <= 1'b0;
         rq_s2 <= 1'b0;
      end else begin
         rq_s1 <= req;
         rq_s2 <= rq_s1;
      end
   end
   // ==========================================
   // serializer
   das_lk_st_t lk_state;
   logic [4:0] lk_cnt, lk_nb;
   logic [15:0] lk_sh1, lk_sh2;
   logic lk_one, lk_par, lk_pend, lk_last, lk_take, lk_frame;
   logic [1:0] lk_len;
   assign lk_nb = das_bits_per_lane(lk_one, lk_len);
   assign lk_pend = (rq_s2 != lk_ack);
   assign lk_last = (lk_state == LK_SEND) && (lk_cnt == lk_nb - 5'h01);
   assign lk_take = lk_pend && (lk_state == LK_IDLE || lk_last);
   // two-lane fourteen-bit frames span two samples, so follow parity
   assign lk_frame = (!lk_one && lk_len == LEN_14) ? lk_par : (lk_cnt < (lk_nb >> 1));
   always_ff @(posedge bit_clk or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_state <= LK_IDLE;
         lk_cnt <= 5'h00;
         lk_sh1 <= 16'h0000;
         lk_sh2 <= 16'h0000;
         lk_one <= 1'b0;
         lk_len <= LEN_16;
         lk_par <= 1'b0;
         lk_ack <= 1'b0;
      end else if (lk_take) begin
         lk_state <= LK_SEND;
         lk_cnt <= 5'h00;
         lk_sh1 <= {xfer_word.chan1, 4'h0};
         lk_sh2 <= {xfer_word.chan2, 4'h0};
         lk_one <= xfer_word.one_lane;
         lk_len <= xfer_word.ser_len;
         lk_par <= !lk_par;
         lk_ack <= rq_s2;
      end else if (lk_last) begin
         lk_state <= LK_IDLE;
      end else if (lk_state == LK_SEND) begin
         lk_cnt <= lk_cnt + 5'h01;
         lk_sh1 <= lk_one ? {lk_sh1[14:0], 1'b0} : {lk_sh1[13:0], 2'b00};
         lk_sh2 <= lk_one ? {lk_sh2[14:0], 1'b0} : {lk_sh2[13:0], 2'b00};
      end
   end
   always_ff @(posedge bit_clk or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         chan1_lane_first <= 1'b0;
         chan1_lane_second <= 1'b0;
         chan2_lane_first <= 1'b0;
         chan2_lane_second <= 1'b0;
         frame_marker <= 1'b0;
      end else if (lk_state == LK_SEND) begin
         chan1_lane_first <= lk_sh1[15];
         chan2_lane_first <= lk_sh2[15];
         chan1_lane_second <= lk_one ? 1'b0 : lk_sh1[14];
         chan2_lane_second <= lk_one ? 1'b0 : lk_sh2[14];
         frame_marker <= lk_frame;
      end else begin
         chan1_lane_first <= 1'b0;
         chan1_lane_second <= 1'b0;
         chan2_lane_first <= 1'b0;
         chan2_lane_second <= 1'b0;
         frame_marker <= 1'b0;
      end
   end
   // both edges of this clock mark a bit for the receiver
   always_ff @(posedge bit_clk or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         forwarded_bit_clock <= 1'b0;
      end else begin
         forwarded_bit_clock <= !forwarded_bit_clock;
      end
   end
   // ==========================================
   // checks
   a_conv_start: assert property (@(posedge clk) disable iff (!nrst)
      enc_edge && !cfg.power_down |=> pv[0] && pipe[0].chan1 == $past(chan1_code)
      && pipe[0].chan2 == $past(chan2_code)) else $error("conversion not started on encode edge");
   a_one_lane_idle: assert property (@(posedge bit_clk) disable iff (!lk_rst_n)
      lk_state == LK_SEND && lk_one |=> !chan1_lane_second && !chan2_lane_second)
      else $error("second lane active in one-lane mode");
   a_lane_order: assert property (@(posedge bit_clk) disable iff (!lk_rst_n)
      lk_state == LK_SEND && !lk_one |=> chan1_lane_first == $past(lk_sh1[15])
      && chan1_lane_second == $past(lk_sh1[14])) else $error("two-lane bit order wrong");
   a_pad_zero: assert property (@(posedge bit_clk) disable iff (!lk_rst_n)
      lk_state == LK_SEND && !lk_one && lk_len == LEN_16 && lk_cnt == 5'h06
      |=> !chan1_lane_first && !chan1_lane_second && !chan2_lane_first) else $error("padding bits not zero");
   a_frame_double: assert property (@(posedge bit_clk) disable iff (!lk_rst_n)
      lk_take && lk_state == LK_SEND && !lk_one && lk_len == LEN_14 && !xfer_word.one_lane
      && xfer_word.ser_len == LEN_14 |=> ##1 frame_marker != $past(frame_marker))
      else $error("frame marker did not alternate per sample");
   a_nb_len: assert property (@(posedge bit_clk) disable iff (!lk_rst_n)
      lk_state == LK_SEND && lk_one && lk_len == LEN_12 |-> lk_nb == 5'h0C && lk_cnt < 5'h0C)
      else $error("one-lane twelve-bit length wrong");
endmodule // das_top

// File: das_rx_model.sv
/*
 das_rx_model: far-end receiver of the serial lanes; rebuilds both codes.
 assumes: strobe falls mid-bit; the bench gives the lane mode of the sample
 in flight and holds enable low when no sample is expected.
*/
module das_rx_model (
   // capture
   input wire logic strobe,
   input wire logic nrst,
   input wire logic enable,
   input wire logic one_lane,
   input wire logic [1:0] ser_len,
   // lanes
   input wire logic lane1a,
   input wire logic lane1b,
   input wire logic lane2a,
   input wire logic lane2b,
   input wire logic frame,
   // rebuilt sample
   output logic rx_valid,
   output logic [das_pkg::RES_W-1:0] rx_code1,
   output logic [das_pkg::RES_W-1:0] rx_code2,
   output logic rx_bad
);
   import das_pkg::*;
   logic [15:0] acc1, acc2, n1, n2, pad;
   logic [4:0] cnt, nb, step;
   logic frame_q, start, last;
   assign nb = (ser_len == LEN_14) ? 5'h0E : ((ser_len == LEN_12) ? 5'h0C : 5'h10);
   assign step = one_lane ? 5'h01 : 5'h02;
   assign start = frame && !frame_q;
   assign last = (cnt != 5'h00 || start) && (cnt + step >= nb);
   assign n1 = one_lane ? {acc1[14:0], lane1a} : {acc1[13:0], lane1a, lane1b};
   assign n2 = one_lane ? {acc2[14:0], lane2a} : {acc2[13:0], lane2a, lane2b};
   assign pad = (n1 | n2) & ((16'h0001 << (nb - 5'h0C)) - 16'h0001);
   // ==========================================
   // capture half a bit after each forwarded clock edge, clear of the transitions
   always @(negedge strobe or negedge nrst) begin
      if (!nrst) begin
         cnt <= 5'h00;
         frame_q <= 1'b0;
         rx_valid <= 1'b0;
         rx_bad <= 1'b0;
      end else begin
         frame_q <= frame;
         rx_valid <= last && enable;
         rx_bad <= enable && ((start && cnt != 5'h00) || (one_lane && (lane1b || lane2b))
            || (last && pad != 16'h0000));
         if (!enable || last) begin
            cnt <= 5'h00;
         end else if (cnt != 5'h00 || start) begin
            cnt <= cnt + step;
         end
         acc1 <= n1;
         acc2 <= n2;
         rx_code1 <= 12'(n1 >> (nb - 5'h0C));
         rx_code2 <= 12'(n2 >> (nb - 5'h0C));
      end
   end
endmodule // das_rx_model

// File: testbench.sv
/*
 testbench: drives the converter block at its pins, checks configuration
 and the rebuilt lane data against queued expectations.
 assumes: the das design files and das_rx_model are compiled first.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import das_pkg::*;
   typedef struct packed {
      logic [11:0] c1;
      logic [11:0] c2;
      logic one;
      logic [1:0] len;
   } das_exp_t;
   // ==========================================
   // signals
   logic clk = 1'b0, nrst = 1'b0, bit_clk = 1'b0, enc_p = 1'b0, cs_n = 1'b1, sck = 1'b0, sdi = 1'b0;
   logic programming_mode_select = 1'b0, term_pin = 1'b0, bc_hold = 1'b0, fw_q = 1'b0, cnt_on = 1'b0;
   logic rx_en = 1'b0, rx_one = 1'b0, fr_q = 1'b0, sdo_i, sdo_o, sdo_oe, sample_overrun, fwd_clk;
   logic l1a, l1b, l2a, l2b, frame_marker, rx_valid, rx_bad;
   logic [1:0] rx_len = 2'h0;
   logic [2:0] cur = 3'h0;
   logic [11:0] chan1_code = 12'h000, chan2_code = 12'h000, rx_code1, rx_code2;
   das_cfg_t cfg;
   das_exp_t q[$];
   das_exp_t e;
   integer seed = 32'h8A8E5A08;
   int failures = 0, n_tests = 0, rises = 0, ovr = 0;
   // ==========================================
   // design and far end
   das_top das_top_inst (.clk(clk), .nrst(nrst), .bit_clk(bit_clk), .enc_p(enc_p), .chan1_code(chan1_code),
      .chan2_code(chan2_code), .programming_mode_select(programming_mode_select), .cs_n(cs_n), .sck(sck),
      .sdi(sdi), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cfg(cfg), .sample_overrun(sample_overrun),
      .chan1_lane_first(l1a), .chan1_lane_second(l1b), .chan2_lane_first(l2a), .chan2_lane_second(l2b),
      .frame_marker(frame_marker), .forwarded_bit_clock(fwd_clk));
   das_rx_model das_rx_model_inst (.strobe(bit_clk), .nrst(nrst), .enable(rx_en), .one_lane(rx_one),
      .ser_len(rx_len), .lane1a(l1a), .lane1b(l1b), .lane2a(l2a), .lane2b(l2b), .frame(frame_marker),
      .rx_valid(rx_valid), .rx_code1(rx_code1), .rx_code2(rx_code2), .rx_bad(rx_bad));
   // open-drain wire with pull-up; in parallel mode the pin is a plain input
   assign sdo_i = programming_mode_select ? term_pin : (sdo_oe ? sdo_o : 1'b1);
   always #12.5 clk = ~clk;
   // bit rate kept well above the serial floor
   initial begin
      #1.7;
      forever begin
         #3;
         if (!bc_hold) bit_clk = ~bit_clk;
      end
   end
   // ==========================================
   // checking
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge bit_clk) begin
      rx_en <= q.size() != 0;
      rx_one <= (q.size() != 0) ? q[0].one : 1'b0;
      rx_len <= (q.size() != 0) ? q[0].len : 2'h0;
   end
   always @(posedge clk) begin
      if (sample_overrun === 1'b1) ovr <= ovr + 1;
   end
   always @(negedge bit_clk) begin
      fr_q <= frame_marker;
      fw_q <= fwd_clk;
      if (rx_en) check("fwd_clock", 32'(fwd_clk), 32'(!fw_q));
      if (cnt_on && frame_marker && !fr_q) rises <= rises + 1;
      if (rx_bad === 1'b1) check("lane_format", 32'(rx_bad), 32'h0);
      if (rx_valid === 1'b1 && q.size() == 0) check("extra_sample", 32'h1, 32'h0);
      if (rx_valid === 1'b1 && q.size() != 0) begin
         e = q.pop_front();
         check("chan1", 32'(rx_code1), 32'(e.c1));
         check("chan2", 32'(rx_code2), 32'(e.c2));
      end
   end
   // ==========================================
   // stimulus
   task automatic spi(input logic sel, input logic [15:0] w, output logic [7:0] r);
      r = 8'h00;
      cs_n <= !sel;
      repeat (6) @(posedge clk);
      for (int i = 15; i >= 0; i--) begin
         sck <= 1'b0;
         sdi <= w[i];
         repeat (6) @(posedge clk);
         sck <= 1'b1;
         repeat (6) @(posedge clk);
         r = {r[6:0], sdo_i};
      end
      sck <= 1'b0;
      repeat (6) @(posedge clk);
      cs_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic enc(input int n, input logic keep);
      logic [11:0] c1, c2;
      repeat (n) begin
         c1 = 12'($random(seed));
         c2 = 12'($random(seed));
         chan1_code <= c1;
         chan2_code <= c2;
         repeat (4) @(posedge clk);
         enc_p <= 1'b1;
         if (keep) q.push_back({c1, c2, cur[0], cur[2:1]});
         repeat (4) @(posedge clk);
         enc_p <= 1'b0;
      end
   endtask
   // encode count is small, so the limit leaves a wide margin
   initial begin
      #400000;
      failures = failures + 1;
      summarize();
   end
   initial begin
      logic [7:0] r, d;
      logic [2:0] modes [6];
      modes = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h2};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      check("cfg_reset", 32'(cfg), 32'h20);
      spi(1'b1, 16'h8100, r);
      check("read_power", 32'(r), 32'h02);
      spi(1'b1, 16'h8500, r);
      check("read_unmapped", 32'(r), 32'h00);
      spi(1'b0, 16'h021F, r);
      check("cfg_unselected", 32'(cfg), 32'h20);
      for (int k = 0; k < 6; k++) begin
         cur = modes[k];
         d = {3'h0, 2'($random(seed)), cur};
         spi(1'b1, {8'h02, d}, r);
         check("cfg_write", 32'(cfg), 32'({2'b01, d[3], d[4], d[0], d[2:1]}));
         spi(1'b1, {8'h82, d}, r);
         check("read_output", 32'(r), 32'(d));
         enc(8, k != 5);
         if (k == 5) begin
            rises = 0;
            cnt_on <= 1'b1;
            enc(8, 1'b0);
            cnt_on <= 1'b0;
            check("frame_period", 32'(rises), 32'h4);
         end
      end
      check("pending", 32'(q.size()), 32'h0);
      check("no_overrun", 32'(ovr), 32'h0);
      // stop the idle link: one word waits in the crossing, four fill the buffer, the sixth drops
      repeat (8) @(posedge clk);
      bc_hold <= 1'b1;
      enc(6, 1'b0);
      repeat (2) @(posedge clk);
      check("overrun", 32'(ovr), 32'h1);
      bc_hold <= 1'b0;
      spi(1'b1, 16'h0103, r);
      check("power_down", 32'(cfg.power_down), 32'h1);
      programming_mode_select <= 1'b1;
      cs_n <= 1'b1;
      sdi <= 1'b0;
      sck <= 1'b1;
      term_pin <= 1'b1;
      repeat (8) @(posedge clk);
      check("par_a", 32'(cfg), 32'h3C);
      cs_n <= 1'b0;
      sck <= 1'b0;
      sdi <= 1'b1;
      term_pin <= 1'b0;
      repeat (8) @(posedge clk);
      check("par_b", 32'(cfg), 32'h60);
      summarize();
   end
endmodule // testbench
